// File: src/nvmcu_pkg.sv
// Purpose: Constants and carrier types of the NVM command unit
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Functional notes follow
package nvmcu_pkg;
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_ADDR   = 8'h08;
    localparam logic [7:0] OFS_DATA_BYTE_ZERO  = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_CTRL_B = 8'h14;
    localparam logic [7:0] OFS_LOCK   = 8'h18;
    localparam logic [7:0] OFS_UNLOCK = 8'h1C;
    localparam int         BIT_COMMAND_EXECUTE_BIT  = 0;
    localparam int         BIT_BUSY   = 0;
    localparam int         BIT_MAP    = 0;
    // Unlock key value is arbitrary
    localparam logic [7:0] UNLOCK_KEY = 8'h5A;
    localparam int         UNLOCK_WIN = 4;
    localparam logic [6:0] CMD_NOP      = 7'h00;
    localparam logic [6:0] CMD_SIG_USER = 7'h01;
    localparam logic [6:0] CMD_SIG_PROD = 7'h02;
    localparam logic [6:0] CMD_RD_EE    = 7'h06;
    localparam logic [6:0] CMD_RD_FUSE  = 7'h07;
    localparam logic [6:0] CMD_WR_LOCK  = 7'h08;
    localparam logic [6:0] CMD_ERA_EE   = 7'h30;
    localparam logic [6:0] CMD_ERA_PAGE = 7'h32;
    localparam logic [6:0] CMD_LD_BUF   = 7'h33;
    localparam logic [6:0] CMD_WR_PAGE  = 7'h34;
    localparam logic [6:0] CMD_EW_PAGE  = 7'h35;
    localparam logic [6:0] CMD_ERA_BUF  = 7'h36;
    localparam int FUSE_CYCLES = 4;
    localparam int LOCK_CYCLES = 8;
    localparam int BUF_CYCLES  = 2;
    localparam int PAGE_CYCLES = 16;
    localparam int MAP_HALT    = 2;
    localparam logic [7:0] ERASED   = 8'hFF;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    localparam logic [7:0] FUSE_RST = 8'hFF;
    localparam logic [7:0] SIG_SEED = 8'hA5;
    typedef enum logic [1:0] {TRIG_NONE, TRIG_EXEC, TRIG_LOAD, TRIG_STORE}
        nvmcu_trig_t;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } nvmcu_wb_req_t;
    typedef struct packed {
        logic        store;
        logic        load;
        logic [15:0] addr;
        logic [7:0]  data;
    } nvmcu_cpu_req_t;
endpackage : nvmcu_pkg

// File: src/nvmcu_top.sv
// Purpose: NVM fuse, lock and EEPROM command unit behind Wishbone
// Assumes: Single clk_in at 100 MHz, synchronous active-low reset
// Notes: EEPROM, fuses and page buffer are held in local arrays
`timescale 1ns/1ps
`default_nettype none
module nvmcu_top #(
    parameter int ADDR_W      = 12,
    parameter int PAGE_BYTES  = 32,
    parameter int FUSE_NUM    = 8,
    parameter int PAGE_CYC    = nvmcu_pkg::PAGE_CYCLES,
    parameter int FUSE_CYC    = nvmcu_pkg::FUSE_CYCLES,
    parameter int LOCK_CYC    = nvmcu_pkg::LOCK_CYCLES
) (
    input  wire logic                     clk_in,
    input  wire logic                     rst_n_in,
    input  wire nvmcu_pkg::nvmcu_wb_req_t wb_req_in,
    output logic                          wb_ack_out,
    output logic [31:0]                   wb_dat_out,
    input  wire nvmcu_pkg::nvmcu_cpu_req_t cpu_req_in,
    input  wire logic                     ext_prog_in,
    output logic [7:0]                    cpu_load_data_out,
    output logic                          cpu_load_valid_out,
    output logic                          cpu_halt_out,
    output logic                          busy_out,
    output logic                          flash_buf_erase_out,
    output logic [7:0]                    lock_out
);
    localparam int BYTE_W = $clog2(PAGE_BYTES);
    localparam int EE_BYTES = 1 << ADDR_W;
    localparam int FUSE_AW = $clog2(FUSE_NUM);

    if (PAGE_BYTES < 2 || (1 << BYTE_W) != PAGE_BYTES
        || ADDR_W <= BYTE_W || ADDR_W > 16) begin : g_bad_geom
        $error("nvmcu_top: unsupported page or address geometry");
    end
    if (PAGE_CYC < 1 || FUSE_CYC < 1 || LOCK_CYC < 1
        || PAGE_CYC > 65535 || FUSE_CYC > 65535 || LOCK_CYC > 65535
        || FUSE_NUM < 2) begin : g_bad_cnt
        $error("nvmcu_top: unsupported cycle counts or fuse count");
    end

    typedef enum logic {ST_IDLE, ST_RUN} nvmcu_state_t;

    function automatic nvmcu_pkg::nvmcu_trig_t trig_of(input logic [6:0] c);
        unique case (c)
            nvmcu_pkg::CMD_SIG_USER,
            nvmcu_pkg::CMD_SIG_PROD: trig_of = nvmcu_pkg::TRIG_LOAD;
            nvmcu_pkg::CMD_RD_EE,
            nvmcu_pkg::CMD_RD_FUSE,
            nvmcu_pkg::CMD_WR_LOCK,
            nvmcu_pkg::CMD_ERA_EE,
            nvmcu_pkg::CMD_ERA_PAGE,
            nvmcu_pkg::CMD_WR_PAGE,
            nvmcu_pkg::CMD_EW_PAGE,
            nvmcu_pkg::CMD_ERA_BUF:  trig_of = nvmcu_pkg::TRIG_EXEC;
            default:                 trig_of = nvmcu_pkg::TRIG_NONE;
        endcase
    endfunction : trig_of

    function automatic logic [15:0] run_len(input logic [6:0] c);
        unique case (c)
            nvmcu_pkg::CMD_RD_FUSE: run_len = 16'(FUSE_CYC);
            nvmcu_pkg::CMD_WR_LOCK: run_len = 16'(LOCK_CYC);
            nvmcu_pkg::CMD_ERA_BUF: run_len = 16'(nvmcu_pkg::BUF_CYCLES);
            default:                run_len = 16'(PAGE_CYC);
        endcase
    endfunction : run_len

    // Stand-in signature rows; contents are arbitrary
    function automatic logic [7:0] sig_byte(input logic prod,
                                            input logic [15:0] a);
        sig_byte = a[7:0] ^ nvmcu_pkg::SIG_SEED ^ {7'h00, prod};
    endfunction : sig_byte

    logic [7:0]          ee_mem_q [EE_BYTES];
    logic [7:0]          buf_q    [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] tag_q;
    logic [7:0]          fuse_q   [FUSE_NUM];
    logic                ack_q;
    logic [31:0]         rdat_q;
    logic [6:0]          cmd_q;
    logic [15:0]         addr_q;
    logic [7:0]          data_byte_zero_q;
    logic                map_q;
    logic [7:0]          lock_q;
    logic [2:0]          unlock_q;
    logic                ext_s1_q;
    logic                ext_s2_q;
    nvmcu_state_t        state_q;
    logic [6:0]          run_cmd_q;
    logic [15:0]         cnt_q;
    logic                busy_q;
    logic                halt_cmd_q;
    logic [1:0]          map_halt_q;
    logic                halt_q;
    logic [7:0]          ld_data_q;
    logic                ld_valid_q;
    logic                fbuf_clr_q;

    logic                wb_req;
    logic                wb_wr;
    logic                ccp_ok;
    logic                exec_go;
    logic                buf_load;
    logic                map_load;
    logic                done;
    logic                rd_ee_go;
    logic [BYTE_W-1:0]   ld_idx;
    logic [ADDR_W-BYTE_W-1:0] cur_page;
    logic [31:0]         rd_mux;

    always_comb begin
        wb_req = wb_req_in.cyc & wb_req_in.stb & ~ack_q;
        wb_wr  = wb_req & wb_req_in.we & wb_req_in.sel[0];
        ccp_ok = (unlock_q != 3'h0) | ext_s2_q;
        exec_go = wb_wr & (wb_req_in.adr == nvmcu_pkg::OFS_CTRL_A)
                & wb_req_in.dat[nvmcu_pkg::BIT_COMMAND_EXECUTE_BIT] & ccp_ok & ~busy_q
                & (trig_of(cmd_q) == nvmcu_pkg::TRIG_EXEC)
                & ~(map_q & (cmd_q == nvmcu_pkg::CMD_RD_EE));
        rd_ee_go = exec_go & (cmd_q == nvmcu_pkg::CMD_RD_EE);
        buf_load = wb_wr & (wb_req_in.adr == nvmcu_pkg::OFS_DATA_BYTE_ZERO)
                 & (cmd_q == nvmcu_pkg::CMD_LD_BUF) & ccp_ok & ~busy_q
                 & ~map_q;
        map_load = cpu_req_in.store & map_q & ~busy_q;
        done = (state_q == ST_RUN) & (cnt_q == 16'h0000);
        ld_idx = map_load ? cpu_req_in.addr[BYTE_W-1:0]
                          : addr_q[BYTE_W-1:0];
        cur_page = addr_q[ADDR_W-1:BYTE_W];
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (wb_req_in.adr)
            nvmcu_pkg::OFS_CMD:    rd_mux = {25'h000_0000, cmd_q};
            nvmcu_pkg::OFS_ADDR:   rd_mux = {16'h0000, addr_q};
            nvmcu_pkg::OFS_DATA_BYTE_ZERO:  rd_mux = {24'h00_0000, data_byte_zero_q};
            nvmcu_pkg::OFS_STATUS: rd_mux = {31'h0000_0000, busy_q};
            nvmcu_pkg::OFS_CTRL_B: rd_mux = {31'h0000_0000, map_q};
            nvmcu_pkg::OFS_LOCK:   rd_mux = {24'h00_0000, lock_q};
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus answer: ack one cycle after the request, then drop
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= wb_req;
            rdat_q <= wb_req ? rd_mux : 32'h0000_0000;
        end
    end
    // External programming pin is asynchronous
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_prog_in;
            ext_s2_q <= ext_s1_q;
        end
    end
    // Unlock window closes after a fixed number of cycles
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            unlock_q <= 3'h0;
        end else if (wb_wr && wb_req_in.adr == nvmcu_pkg::OFS_UNLOCK
                     && wb_req_in.dat[7:0] == nvmcu_pkg::UNLOCK_KEY) begin
            unlock_q <= 3'(nvmcu_pkg::UNLOCK_WIN);
        end else if (unlock_q != 3'h0) begin
            unlock_q <= unlock_q - 3'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cmd_q <= nvmcu_pkg::CMD_NOP;
        end else if (wb_wr && wb_req_in.adr == nvmcu_pkg::OFS_CMD) begin
            cmd_q <= wb_req_in.dat[6:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_q <= 16'h0000;
        end else if (wb_req & wb_req_in.we
                     && wb_req_in.adr == nvmcu_pkg::OFS_ADDR) begin
            if (wb_req_in.sel[0]) begin
                addr_q[7:0] <= wb_req_in.dat[7:0];
            end
            if (wb_req_in.sel[1]) begin
                addr_q[15:8] <= wb_req_in.dat[15:8];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            map_q <= 1'b0;
        end else if (wb_wr && wb_req_in.adr == nvmcu_pkg::OFS_CTRL_B) begin
            map_q <= wb_req_in.dat[nvmcu_pkg::BIT_MAP];
        end
    end
    // Hardware results win over a bus write in the same cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            data_byte_zero_q <= 8'h00;
        end else if (rd_ee_go) begin
            data_byte_zero_q <= ee_mem_q[addr_q[ADDR_W-1:0]];
        end else if (done && run_cmd_q == nvmcu_pkg::CMD_RD_FUSE) begin
            data_byte_zero_q <= fuse_q[addr_q[FUSE_AW-1:0]];
        end else if (wb_wr && wb_req_in.adr == nvmcu_pkg::OFS_DATA_BYTE_ZERO) begin
            data_byte_zero_q <= wb_req_in.dat[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            lock_q <= nvmcu_pkg::LOCK_RST;
        end else if (done && run_cmd_q == nvmcu_pkg::CMD_WR_LOCK) begin
            lock_q <= lock_q & data_byte_zero_q;
        end
    end
    // Fuses are read-only here; their programming is done elsewhere
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < FUSE_NUM; i++) begin
            if (!rst_n_in) begin
                fuse_q[i] <= nvmcu_pkg::FUSE_RST;
            end
        end
    end
    // Command sequencer
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q   <= ST_IDLE;
            run_cmd_q <= nvmcu_pkg::CMD_NOP;
            cnt_q     <= 16'h0000;
            busy_q    <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (exec_go && !rd_ee_go) begin
                        state_q   <= ST_RUN;
                        run_cmd_q <= cmd_q;
                        cnt_q     <= run_len(cmd_q) - 16'h0001;
                        busy_q    <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (done) begin
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
            endcase
        end
    end
    // CPU halt: fuse read and lock write, plus mapped buffer loads
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            halt_cmd_q <= 1'b0;
            map_halt_q <= 2'h0;
            halt_q     <= 1'b0;
        end else begin
            if (exec_go && (cmd_q == nvmcu_pkg::CMD_RD_FUSE
                            || cmd_q == nvmcu_pkg::CMD_WR_LOCK)) begin
                halt_cmd_q <= 1'b1;
                halt_q     <= 1'b1;
            end else if (done) begin
                halt_cmd_q <= 1'b0;
                halt_q     <= map_halt_q > 2'h1;
            end else if (map_load) begin
                map_halt_q <= 2'(nvmcu_pkg::MAP_HALT);
                halt_q     <= 1'b1;
            end else if (map_halt_q != 2'h0) begin
                map_halt_q <= map_halt_q - 2'h1;
                halt_q     <= halt_cmd_q | (map_halt_q > 2'h1);
            end
        end
    end

    // Page buffer and its tags
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tag_q <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                buf_q[i] <= nvmcu_pkg::ERASED;
            end
        end else if (done && (run_cmd_q == nvmcu_pkg::CMD_ERA_BUF
                              || run_cmd_q == nvmcu_pkg::CMD_WR_LOCK
                              || run_cmd_q == nvmcu_pkg::CMD_WR_PAGE
                              || run_cmd_q == nvmcu_pkg::CMD_EW_PAGE)) begin
            tag_q <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                buf_q[i] <= nvmcu_pkg::ERASED;
            end
        end else if (buf_load || map_load) begin
            buf_q[ld_idx] <= map_load ? cpu_req_in.data : wb_req_in.dat[7:0];
            tag_q[ld_idx] <= 1'b1;
        end
    end

    // EEPROM array updates at command completion, tagged bytes only
    always_ff @(posedge clk_in) begin
        if (done) begin
            for (int i = 0; i < EE_BYTES; i++) begin
                if (tag_q[i % PAGE_BYTES]) begin
                    if (run_cmd_q == nvmcu_pkg::CMD_ERA_EE) begin
                        ee_mem_q[i] <= nvmcu_pkg::ERASED;
                    end else if ((i / PAGE_BYTES) == int'(cur_page)) begin
                        unique case (run_cmd_q)
                            nvmcu_pkg::CMD_ERA_PAGE:
                                ee_mem_q[i] <= nvmcu_pkg::ERASED;
                            nvmcu_pkg::CMD_WR_PAGE:
                                ee_mem_q[i] <= ee_mem_q[i]
                                             & buf_q[i % PAGE_BYTES];
                            nvmcu_pkg::CMD_EW_PAGE:
                                ee_mem_q[i] <= buf_q[i % PAGE_BYTES];
                            default: ;
                        endcase
                    end
                end
            end
        end
    end

    // Signature row and mapped EEPROM read on the CPU load path
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ld_data_q  <= 8'h00;
            ld_valid_q <= 1'b0;
        end else begin
            ld_valid_q <= 1'b0;
            if (cpu_req_in.load && map_q) begin
                ld_data_q  <= ee_mem_q[cpu_req_in.addr[ADDR_W-1:0]];
                ld_valid_q <= 1'b1;
            end else if (cpu_req_in.load
                         && trig_of(cmd_q) == nvmcu_pkg::TRIG_LOAD) begin
                ld_data_q  <= sig_byte(cmd_q == nvmcu_pkg::CMD_SIG_PROD,
                                       cpu_req_in.addr);
                ld_valid_q <= 1'b1;
            end
        end
    end

    // Flash buffer lives elsewhere; pulse its clear on lock write
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fbuf_clr_q <= 1'b0;
        end else begin
            fbuf_clr_q <= done && run_cmd_q == nvmcu_pkg::CMD_WR_LOCK;
        end
    end

    assign wb_ack_out          = ack_q;
    assign wb_dat_out          = rdat_q;
    assign cpu_load_data_out   = ld_data_q;
    assign cpu_load_valid_out  = ld_valid_q;
    assign cpu_halt_out        = halt_q;
    assign busy_out            = busy_q;
    assign flash_buf_erase_out = fbuf_clr_q;
    assign lock_out            = lock_q;
endmodule : nvmcu_top
`default_nettype wire

// File: tb/nvmcu_chk.sv
// Purpose: Port-level assertions for nvmcu_top
// Assumes: One clock, synchronous active-low reset
// Notes: Busy bound is loose, the sum of all command lengths
`timescale 1ns/1ps
`default_nettype none
module nvmcu_chk #(
    parameter int PAGE_CYC = 16,
    parameter int FUSE_CYC = 4,
    parameter int LOCK_CYC = 8
) (
    input wire logic                      clk_in,
    input wire logic                      rst_n_in,
    input wire nvmcu_pkg::nvmcu_wb_req_t  wb_req_in,
    input wire logic                      wb_ack_out,
    input wire nvmcu_pkg::nvmcu_cpu_req_t cpu_req_in,
    input wire logic                      cpu_load_valid_out,
    input wire logic                      cpu_halt_out,
    input wire logic                      busy_out,
    input wire logic                      flash_buf_erase_out,
    input wire logic [7:0]                lock_out
);
    localparam int MAX_BUSY = PAGE_CYC + FUSE_CYC + LOCK_CYC + 2;
    logic take;
    logic exec_take;
    logic st_map;
    logic ld;
    logic map_q;
    logic live_q;
    assign take = wb_req_in.cyc && wb_req_in.stb && !wb_ack_out;
    assign exec_take = take && wb_req_in.we && wb_req_in.dat[0]
                       && wb_req_in.adr == nvmcu_pkg::OFS_CTRL_A;
    assign st_map = cpu_req_in.store && map_q;
    assign ld = cpu_req_in.load;
    // Mapping state shadowed so mapped stores can be judged
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            map_q <= 1'b0;
        end else if (take && wb_req_in.we && wb_req_in.sel[0]
                     && wb_req_in.adr == nvmcu_pkg::OFS_CTRL_B) begin
            map_q <= wb_req_in.dat[0];
        end
    end
    // Checks wait one edge past release, until $past is clean
    always_ff @(posedge clk_in) begin
        live_q <= rst_n_in;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in || !live_q);
    property p_ack; take |=> wb_ack_out ##1 !wb_ack_out; endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle");
    property p_busy_cause; $rose(busy_out) |-> $past(exec_take);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy without execute write");
    property p_busy_end; $rose(busy_out) |-> ##[1:MAX_BUSY] !busy_out;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy never clears");
    property p_halt; cpu_halt_out |-> busy_out || $past(st_map)
        || $past(st_map, 2); endproperty
    a_halt: assert property (p_halt)
        else $error("halt without cause");
    property p_map_halt; st_map |=> cpu_halt_out [*2]; endproperty
    a_map_halt: assert property (p_map_halt)
        else $error("mapped store halt short");
    property p_load; ld |=> cpu_load_valid_out; endproperty
    a_load: assert property (p_load)
        else $error("load gave no byte");
    property p_fbe; flash_buf_erase_out |-> !busy_out && $past(busy_out)
        ##1 !flash_buf_erase_out; endproperty
    a_fbe: assert property (p_fbe)
        else $error("flash buffer erase pulse misplaced");
    property p_lock; !$stable(lock_out) |->
        (lock_out & ~$past(lock_out)) == 8'h00; endproperty
    a_lock: assert property (p_lock)
        else $error("lock bits moved to less secure");
endmodule : nvmcu_chk
bind nvmcu_top nvmcu_chk #(.PAGE_CYC(PAGE_CYC), .FUSE_CYC(FUSE_CYC),
    .LOCK_CYC(LOCK_CYC)) u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .wb_req_in(wb_req_in), .wb_ack_out(wb_ack_out),
    .cpu_req_in(cpu_req_in), .cpu_load_valid_out(cpu_load_valid_out),
    .cpu_halt_out(cpu_halt_out), .busy_out(busy_out),
    .flash_buf_erase_out(flash_buf_erase_out), .lock_out(lock_out));
`default_nettype wire

// File: tb/nvmcu_cpu_model.sv
// Purpose: CPU side of the command unit, bus and load/store
// Assumes: Requests change only just after a rising edge
// Notes: No interrupts modelled, so loads are never preempted
`timescale 1ns/1ps
`default_nettype none
module nvmcu_cpu_model (
    input  wire logic                     clk_in,
    input  wire logic                     wb_ack_in,
    input  wire logic [31:0]              wb_dat_in,
    output var nvmcu_pkg::nvmcu_wb_req_t  wb_req_out,
    output var nvmcu_pkg::nvmcu_cpu_req_t cpu_req_out
);
    initial begin
        wb_req_out = '0;
        cpu_req_out = '0;
    end
    // Held until ack, then idle one cycle
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [31:0] dat, output logic [31:0] rd);
        wb_req_out <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr,
                        sel: 4'h3, dat: dat};
        @(posedge clk_in iff wb_ack_in === 1'b1);
        rd = wb_dat_in;
        wb_req_out <= '0;
        @(posedge clk_in);
    endtask : bus
    task automatic cpu(input logic st, input logic ld,
                       input logic [15:0] a, input logic [7:0] d);
        cpu_req_out <= '{store: st, load: ld, addr: a, data: d};
        @(posedge clk_in);
        cpu_req_out <= '0;
        @(posedge clk_in);
    endtask : cpu
endmodule : nvmcu_cpu_model
`default_nettype wire

// File: tb/test_nvmcu_top.sv
// Purpose: Self-checking bench of the NVM command unit
// Assumes: Short command lengths set by parameters
// Notes: Outputs are read just after an edge, before updates
`timescale 1ns/1ps
`default_nettype none
module test_nvmcu_top;
    localparam int PC = 4;
    localparam int FC = 3;
    localparam int LC = 4;
    logic                      clk_in;
    logic                      rst_n_in;
    logic                      ext_prog_in;
    nvmcu_pkg::nvmcu_wb_req_t  wb_req;
    nvmcu_pkg::nvmcu_cpu_req_t cpu_req;
    logic                      wb_ack;
    logic [31:0]               wb_dat;
    logic [7:0]                ld_data;
    logic                      ld_valid;
    logic                      halt;
    logic                      busy;
    logic                      fbe;
    logic [7:0]                lock;
    logic [31:0]               rd;
    int                        n_mismatch;
    int                        samples_checked;
    int                        cycles;
    int                        nb;
    int                        nh;
    int                        nf;
    logic [6:0] row_cmd [0:8] = '{7'h08, 7'h07, 7'h36, 7'h32, 7'h34,
                                  7'h35, 7'h30, 7'h06, 7'h00};
    int row_busy [0:8] = '{LC, FC, nvmcu_pkg::BUF_CYCLES, PC, PC, PC, PC,
                           0, 0};
    int row_halt [0:8] = '{LC, FC, 0, 0, 0, 0, 0, 0, 0};
    nvmcu_top #(.PAGE_CYC(PC), .FUSE_CYC(FC), .LOCK_CYC(LC)) u_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_req_in(wb_req),
        .wb_ack_out(wb_ack), .wb_dat_out(wb_dat), .cpu_req_in(cpu_req),
        .ext_prog_in(ext_prog_in), .cpu_load_data_out(ld_data),
        .cpu_load_valid_out(ld_valid), .cpu_halt_out(halt),
        .busy_out(busy), .flash_buf_erase_out(fbe), .lock_out(lock));
    nvmcu_cpu_model u_cpu (.clk_in(clk_in), .wb_ack_in(wb_ack),
        .wb_dat_in(wb_dat), .wb_req_out(wb_req), .cpu_req_out(cpu_req));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic stop_test();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_cpu.bus(1'b1, a, d, rd);
    endtask : wr
    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] exp);
        u_cpu.bus(1'b0, a, 32'h0000_0000, rd);
        chk(nm, exp, rd);
    endtask : rdchk
    // Window covers the longest command plus the trailing pulse
    task automatic measure();
        nb = 0;
        nh = 0;
        nf = 0;
        repeat (12) begin
            nb += int'(busy === 1'b1);
            nh += int'(halt === 1'b1);
            nf += int'(fbe === 1'b1);
            @(posedge clk_in);
        end
    endtask : measure
    task automatic exec(input logic [6:0] c, input logic [15:0] a,
                        input logic unl);
        wr(nvmcu_pkg::OFS_CMD, 32'(c));
        wr(nvmcu_pkg::OFS_ADDR, 32'(a));
        if (unl) wr(nvmcu_pkg::OFS_UNLOCK, 32'(nvmcu_pkg::UNLOCK_KEY));
        // Busy starts inside the ack cycle, so count alongside the write
        fork
            wr(nvmcu_pkg::OFS_CTRL_A, 32'h0000_0001);
            measure();
        join
    endtask : exec
    task automatic ee_load(input logic [15:0] a, input logic [7:0] d);
        wr(nvmcu_pkg::OFS_ADDR, 32'(a));
        wr(nvmcu_pkg::OFS_UNLOCK, 32'(nvmcu_pkg::UNLOCK_KEY));
        wr(nvmcu_pkg::OFS_DATA_BYTE_ZERO, 32'(d));
    endtask : ee_load
    task automatic ee_rd(input logic [15:0] a, input logic [7:0] d);
        exec(nvmcu_pkg::CMD_RD_EE, a, 1'b1);
        rdchk("ee_byte", nvmcu_pkg::OFS_DATA_BYTE_ZERO, 32'(d));
    endtask : ee_rd
    task automatic do_reset();
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
    endtask : do_reset
    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        cycles = 0;
        rst_n_in = 1'b0;
        ext_prog_in = 1'b0;
        do_reset();
        rdchk("cmd_rst", nvmcu_pkg::OFS_CMD, 32'h0000_0000);
        wr(nvmcu_pkg::OFS_DATA_BYTE_ZERO, 32'h0000_00F0);
        for (int i = 0; i < 9; i++) begin
            exec(row_cmd[i], 16'h0000, 1'b1);
            chk("busy_cycles", 32'(row_busy[i]), 32'(nb));
            chk("halt_cycles", 32'(row_halt[i]), 32'(nh));
            chk("fbe", 32'(row_cmd[i] == 7'h08), 32'(nf));
            if (i == 1) rdchk("fuse", 8'h0C, 32'h0000_00FF);
        end
        chk("lock", 32'h0000_00F0, 32'(lock));
        wr(nvmcu_pkg::OFS_CMD, 32'(nvmcu_pkg::CMD_LD_BUF));
        ee_load(16'h0023, 8'h3C);
        ee_load(16'h0024, 8'hC3);
        exec(nvmcu_pkg::CMD_EW_PAGE, 16'h0020, 1'b1);
        wr(nvmcu_pkg::OFS_CMD, 32'(nvmcu_pkg::CMD_LD_BUF));
        ee_load(16'h0023, 8'h00);
        exec(nvmcu_pkg::CMD_EW_PAGE, 16'h0020, 1'b1);
        ee_rd(16'h0023, 8'h00);
        ee_rd(16'h0024, 8'hC3);
        wr(nvmcu_pkg::OFS_DATA_BYTE_ZERO, 32'h0000_0011);
        wr(nvmcu_pkg::OFS_CTRL_B, 32'h0000_0001);
        exec(nvmcu_pkg::CMD_RD_EE, 16'h0024, 1'b1);
        rdchk("map_data", nvmcu_pkg::OFS_DATA_BYTE_ZERO, 32'h0000_0011);
        u_cpu.cpu(1'b1, 1'b0, 16'h1024, 8'h5A);
        measure();
        chk("map_halt", 32'(nvmcu_pkg::MAP_HALT), 32'(nh));
        u_cpu.cpu(1'b0, 1'b1, 16'h0024, 8'h00);
        chk("map_load", 32'h0000_00C3, 32'(ld_data));
        wr(nvmcu_pkg::OFS_CTRL_B, 32'h0000_0000);
        wr(nvmcu_pkg::OFS_CMD, 32'(nvmcu_pkg::CMD_SIG_USER));
        u_cpu.cpu(1'b0, 1'b1, 16'h0010, 8'h00);
        chk("sig", 32'(8'h10 ^ nvmcu_pkg::SIG_SEED), 32'(ld_data));
        chk("ld_valid", 32'h0000_0001, 32'(ld_valid));
        exec(nvmcu_pkg::CMD_ERA_BUF, 16'h0000, 1'b0);
        chk("locked_exec", 32'h0000_0000, 32'(nb));
        ext_prog_in <= 1'b1;
        // Two-stage synchroniser needs settling edges
        repeat (3) @(posedge clk_in);
        exec(nvmcu_pkg::CMD_ERA_BUF, 16'h0000, 1'b0);
        chk("ext_exec", 32'(nvmcu_pkg::BUF_CYCLES), 32'(nb));
        ext_prog_in <= 1'b0;
        rdchk("unmapped", 8'h20, 32'h0000_0000);
        do_reset();
        rdchk("cmd_rst2", nvmcu_pkg::OFS_CMD, 32'h0000_0000);
        rdchk("status_rst", nvmcu_pkg::OFS_STATUS, 32'h0000_0000);
        stop_test();
    end
endmodule : test_nvmcu_top
`default_nettype wire
